// file: mcg_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// main clock generation block. Assumes inclusion by its bare name.
`ifndef MCG_REGS_SVH
`define MCG_REGS_SVH
`define MCG_ADDR_W          4
`define MCG_OFS_CTRL        4'h0
`define MCG_OFS_TRIM        4'h1
`define MCG_OFS_STATUS      4'h2
`define MCG_OFS_FTRIM5      4'h3
`define MCG_OFS_FTRIM3      4'h4
`define MCG_CTRL_RST        8'h00
`define MCG_TRIM_RST        8'hFF
`define MCG_TRIM_SEARCH     8'h80
`define MCG_BIT_SMS         0
`define MCG_BIT_MCO         1
`define MCG_BIT_LOCK        0
`define MCG_SLOW_DIV        32
`define MCG_STARTUP_NS      64000
`define MCG_CLK_NS          25
`define MCG_STARTUP_CYC     ((`MCG_STARTUP_NS + `MCG_CLK_NS - 1) / `MCG_CLK_NS)
`define MCG_LOCK_NS         6000
`define MCG_LOCK_CYC        ((`MCG_LOCK_NS + `MCG_CLK_NS - 1) / `MCG_CLK_NS)
`endif

// file: mcg_pkg.sv
// Types shared by the main clock generation block.
// Assumes mcg_regs.svh is available for the numeric constants.
package mcg_pkg;
    // Oscillator source selected by option bits.
    typedef enum logic [1:0] {
        MCG_SRC_EXT,
        MCG_SRC_XTAL,
        MCG_SRC_RC
    } mcg_src_t;

    // Option bits that configure the block at reset.
    typedef struct packed {
        mcg_src_t   src;
        logic       pll_on;
        logic       pll_x8;
        logic       tpll_on;
        logic       tdiv2;
    } mcg_opt_t;

    // Register port request.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mcg_bus_t;
endpackage

// file: mcg_div.sv
// Parameterised enable-pulse divider.
// Assumes one clock domain and a synchronous, active-low reset.
`timescale 1ns/10ps
module mcg_div #(
    parameter int DIV = 32
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic tick_i,
    output logic      tick_o
);
    logic [$clog2(DIV)-1:0] cnt_reg;

    // One output pulse for every DIV input pulses.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            tick_o  <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (tick_i) begin
                if (cnt_reg == $clog2(DIV)'(DIV - 1)) begin
                    cnt_reg <= '0;
                    tick_o  <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule

// file: mcg_sync.sv
// Three-stage synchroniser; a change counts when stages two and three agree.
// Assumes an asynchronous input and a synchronous, active-low reset.
`timescale 1ns/10ps
module mcg_sync (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Stage one feeds only stage two, to keep metastability contained.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q_o <= s3_reg;
            end
        end
    end
endmodule

// file: mcg_top.sv
// Main clock generation: source select, PLL start control, slow divider,
// clock output enable, RC trim register and factory trim bytes.
// Assumes analog oscillators and PLLs outside, reporting through levels;
// clocks are modelled as enable ticks on mclk_i.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "mcg_regs.svh"
module mcg_top
    import mcg_pkg::*;
#(
    parameter int STARTUP_CYC = `MCG_STARTUP_CYC,
    parameter int LOCK_CYC    = `MCG_LOCK_CYC,
    parameter int SLOW_DIV    = `MCG_SLOW_DIV
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire mcg_opt_t   opt_i,
    input  wire mcg_bus_t   bus_i,
    output logic [7:0]      rdata_o,
    input  wire logic       ext_clk_tick_i,
    input  wire logic       pin_clk_tick_i,
    input  wire logic       xtal_tick_i,
    input  wire logic       rc_tick_i,
    input  wire logic       pll_tick_i,
    input  wire logic       wake_i,
    input  wire logic       prot_clear_i,
    input  wire logic       ftrim_load_i,
    input  wire logic [7:0] ftrim5_i,
    input  wire logic [7:0] ftrim3_i,
    output logic [7:0]      rc_trim_o,
    output logic [1:0]      pll_mult_o,
    output logic            pll_en_o,
    output logic            tpll_en_o,
    output logic            tpll_div2_o,
    output logic            osc_tick_o,
    output logic            cpu_tick_o,
    output logic            mco_pin_o,
    output logic            mco_pin_oe_n_o,
    output logic            pll_lock_o
);
    typedef enum logic [1:0] {
        MCG_PLL_OFF,
        MCG_PLL_START,
        MCG_PLL_LOCKING,
        MCG_PLL_RUN
    } mcg_pll_st_t;

    logic [7:0]  ctrl_reg;
    logic [7:0]  trim_reg;
    logic [7:0]  ft5_reg;
    logic [7:0]  ft3_reg;
    mcg_pll_st_t pll_st_reg;
    logic [$clog2(STARTUP_CYC+LOCK_CYC+1)-1:0] pll_cnt_reg;
    logic        lock_reg;
    logic        slow_reg;
    logic        ext_tick;
    logic        pin_tick;
    logic        wake_s;
    logic        wake_d_reg;
    logic        src_tick;
    logic        slow_tick;
    logic        mco_reg;

    // External clock, pin clock and wake level arrive from outside the clock domain.
    mcg_sync u_sync_ext (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (ext_clk_tick_i),
        .q_o     (ext_tick)
    );
    mcg_sync u_sync_pin (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pin_clk_tick_i),
        .q_o     (pin_tick)
    );
    mcg_sync u_sync_wake (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (wake_i),
        .q_o     (wake_s)
    );

    // Source tick chosen from option bits; with the PLL on, it is low until the locking state and the PLL tick from then on.
    always_comb begin
        case (opt_i.src)
            MCG_SRC_RC:   src_tick = rc_tick_i;
            MCG_SRC_XTAL: src_tick = xtal_tick_i;
            MCG_SRC_EXT:  src_tick = ext_tick;
            default:      src_tick = pin_tick;
        endcase
        if (opt_i.pll_on) begin
            src_tick = (pll_st_reg != MCG_PLL_OFF && pll_st_reg != MCG_PLL_START)
                       ? pll_tick_i : 1'b0;
        end
    end

    // Multiplier set-up for the analog PLLs, fixed by option bits.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pll_en_o    <= 1'b0;
            pll_mult_o  <= 2'h0;
            tpll_en_o   <= 1'b0;
            tpll_div2_o <= 1'b0;
        end else begin
            pll_en_o    <= opt_i.pll_on;
            pll_mult_o  <= opt_i.pll_x8 ? 2'h3 : 2'h2;
            tpll_en_o   <= opt_i.tpll_on;
            tpll_div2_o <= opt_i.tdiv2 | (opt_i.src == MCG_SRC_XTAL);
        end
    end

    // Startup and lock sequence, restarted on reset and on each rising wake edge.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pll_st_reg  <= MCG_PLL_OFF;
            pll_cnt_reg <= '0;
            lock_reg    <= 1'b0;
            wake_d_reg  <= 1'b0;
        end else begin
            wake_d_reg <= wake_s;
            if (wake_s && !wake_d_reg) begin
                pll_st_reg  <= MCG_PLL_OFF;
                pll_cnt_reg <= '0;
                lock_reg    <= 1'b0;
            end else begin
                case (pll_st_reg)
                    MCG_PLL_OFF: begin
                        if (opt_i.pll_on) begin
                            pll_st_reg <= MCG_PLL_START;
                        end
                    end
                    MCG_PLL_START: begin
                        pll_cnt_reg <= pll_cnt_reg + 1'b1;
                        if (pll_cnt_reg == $bits(pll_cnt_reg)'(STARTUP_CYC - 1)) begin
                            pll_st_reg  <= MCG_PLL_LOCKING;
                            pll_cnt_reg <= '0;
                        end
                    end
                    MCG_PLL_LOCKING: begin
                        pll_cnt_reg <= pll_cnt_reg + 1'b1;
                        if (pll_cnt_reg == $bits(pll_cnt_reg)'(LOCK_CYC - 1)) begin
                            pll_st_reg <= MCG_PLL_RUN;
                            lock_reg   <= 1'b1;
                        end
                    end
                    MCG_PLL_RUN: begin
                        lock_reg <= 1'b1;
                    end
                    default: pll_st_reg <= MCG_PLL_OFF;
                endcase
            end
        end
    end

    // Divide-by-32 enable for slow mode.
    mcg_div #(
        .DIV (SLOW_DIV)
    ) u_slow (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .tick_i  (src_tick),
        .tick_o  (slow_tick)
    );

    // Mode change takes effect only on a divider boundary, so the CPU sees no shortened
    // period when entering slow mode; on leaving it, the first normal tick can come one cycle after the last slow tick.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            slow_reg <= 1'b0;
        end else if (slow_tick) begin
            slow_reg <= ctrl_reg[`MCG_BIT_SMS];
        end
    end

    // Clock ticks to the CPU and the oscillator clock net.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            osc_tick_o <= 1'b0;
            cpu_tick_o <= 1'b0;
        end else begin
            osc_tick_o <= src_tick;
            cpu_tick_o <= slow_reg ? slow_tick : src_tick;
        end
    end

    // Clock out pin toggles on each CPU tick; undriven when disabled.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mco_reg        <= 1'b0;
            mco_pin_o      <= 1'b0;
            mco_pin_oe_n_o <= 1'b1;
        end else begin
            if (cpu_tick_o) begin
                mco_reg <= ~mco_reg;
            end
            mco_pin_o      <= mco_reg;
            mco_pin_oe_n_o <= ~ctrl_reg[`MCG_BIT_MCO];
        end
    end

    // Control register: only the two defined bits are writable.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `MCG_CTRL_RST;
        end else if (bus_i.wr && bus_i.addr == `MCG_OFS_CTRL) begin
            ctrl_reg <= {6'h00, bus_i.wdata[1:0]};
        end
    end

    // Trim register; software must reload its calibration after every reset.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            trim_reg <= `MCG_TRIM_RST;
        end else if (bus_i.wr && bus_i.addr == `MCG_OFS_TRIM) begin
            trim_reg <= bus_i.wdata;
        end
    end

    // The trim word drives the RC oscillator; lower code means faster.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rc_trim_o <= `MCG_TRIM_RST;
        end else begin
            rc_trim_o <= trim_reg;
        end
    end

    // Factory trim bytes, loaded from memory and wiped on protection removal.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ft5_reg <= `MCG_TRIM_RST;
            ft3_reg <= `MCG_TRIM_RST;
        end else if (prot_clear_i) begin
            ft5_reg <= `MCG_TRIM_RST;
            ft3_reg <= `MCG_TRIM_RST;
        end else if (ftrim_load_i) begin
            ft5_reg <= ftrim5_i;
            ft3_reg <= ftrim3_i;
        end
    end

    // Read data in the cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                `MCG_OFS_CTRL:   rdata_o <= ctrl_reg;
                `MCG_OFS_TRIM:   rdata_o <= trim_reg;
                `MCG_OFS_STATUS: rdata_o <= {7'h00, lock_reg};
                `MCG_OFS_FTRIM5: rdata_o <= ft5_reg;
                `MCG_OFS_FTRIM3: rdata_o <= ft3_reg;
                default:         rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Lock level to the pin, one cycle behind the status bit.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pll_lock_o <= 1'b0;
        end else begin
            pll_lock_o <= lock_reg;
        end
    end

    // Checks on the behaviour of this block.
    a_ctrl_rsv_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ctrl_reg[7:2] == 6'h00) else $error("control reserved bits set");
    a_trim_reset_ff: assert property (@(posedge mclk_i)
        !rst_n_i |=> trim_reg == 8'hFF) else $error("trim not FFh after reset");
    a_trim_drives_rc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $changed(trim_reg) |=> rc_trim_o == $past(trim_reg)) else $error("trim not applied");
    a_lock_after_run: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(lock_reg) |-> pll_st_reg == MCG_PLL_RUN) else $error("lock before run");
    a_pll_held_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (opt_i.pll_on && pll_st_reg == MCG_PLL_START) |-> !src_tick)
        else $error("clock out during startup");
    a_rc_direct_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!opt_i.pll_on && opt_i.src == MCG_SRC_RC) |-> src_tick == rc_tick_i)
        else $error("RC not selected");
    a_ext_direct_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!opt_i.pll_on && opt_i.src == MCG_SRC_EXT) |-> src_tick == ext_tick)
        else $error("external not selected");
    a_slow_cpu_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (slow_reg && !slow_tick) |=> !cpu_tick_o) else $error("slow tick extra");
    a_mco_oe_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ##1 mco_pin_oe_n_o == !$past(ctrl_reg[1])) else $error("clock out enable wrong");
    a_slow_switch_edge: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $changed(slow_reg) |-> $past(slow_tick)) else $error("mode switched mid period");
    a_ftrim_erase: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        prot_clear_i |=> ft5_reg == 8'hFF && ft3_reg == 8'hFF) else $error("trim not erased");
endmodule

// file: mcg_src_model.sv
// Behavioural far side of the clock block: external clock pin, default pin,
// crystal, RC oscillator and PLL output. Assumes the bench's mclk_i.
`timescale 1ns/10ps
module mcg_src_model #(
    parameter int HALF = 3
) (
    input  wire logic       mclk_i,
    input  wire logic [4:0] run_i,
    output logic            ext_clk_o = 1'b0,
    output logic            pin_clk_o = 1'b0,
    output logic            xtal_tick_o = 1'b0,
    output logic            rc_tick_o = 1'b0,
    output logic            pll_tick_o = 1'b0
);
    int cnt = 0;

    // Each source runs only while its run bit is set; a stopped one stands low,
    // so a wrongly selected source shows up as missing ticks.
    always @(posedge mclk_i) begin
        cnt <= (cnt + 1) % (2 * HALF);
        ext_clk_o <= run_i[0] && (cnt < HALF);
        pin_clk_o <= run_i[1] && (cnt < HALF);
        xtal_tick_o <= run_i[2] && (cnt % 2 == 0);
        rc_tick_o <= run_i[3] && (cnt % 2 == 1);
        pll_tick_o <= run_i[4];
    end
endmodule

// file: mcg_top_tb.sv
// Self-checking bench for the main clock generation block.
// Assumes mcg_pkg, mcg_regs.svh and the source model are compiled first.
`timescale 1ns/10ps
`include "mcg_regs.svh"
module mcg_top_tb;
    import mcg_pkg::*;
    localparam int ST = 16;
    localparam int LK = 8;
    logic       mclk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    mcg_opt_t   opt_i = '0;
    mcg_bus_t   bus_i = '0;
    logic [4:0] run = 5'h08;
    logic       prot_clear_i = 1'b0;
    logic       ftrim_load_i = 1'b0;
    logic [7:0] ftrim5_i = 8'h00;
    logic [7:0] ftrim3_i = 8'h00;
    logic       wake = 1'b0;
    logic       mco_q = 1'b0;
    int         n_mco = 0;
    logic [7:0] rdata_o;
    logic [7:0] rc_trim_o;
    logic [1:0] pll_mult_o;
    logic       pll_en_o, tpll_en_o, tpll_div2_o, osc_tick_o, cpu_tick_o;
    logic       mco_pin_o, mco_pin_oe_n_o, pll_lock_o;
    logic       ext_clk, pin_clk, xtal_tick, rc_tick, pll_tick;
    int         miscompares = 0;
    int         n_tests = 0;
    int         n_osc = 0;
    int         n_cpu = 0;

    mcg_top #(.STARTUP_CYC(ST), .LOCK_CYC(LK), .SLOW_DIV(32)) mcg_top_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .opt_i(opt_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .ext_clk_tick_i(ext_clk), .pin_clk_tick_i(pin_clk),
        .xtal_tick_i(xtal_tick), .rc_tick_i(rc_tick), .pll_tick_i(pll_tick),
        .wake_i(wake), .prot_clear_i(prot_clear_i), .ftrim_load_i(ftrim_load_i),
        .ftrim5_i(ftrim5_i), .ftrim3_i(ftrim3_i), .rc_trim_o(rc_trim_o),
        .pll_mult_o(pll_mult_o), .pll_en_o(pll_en_o), .tpll_en_o(tpll_en_o),
        .tpll_div2_o(tpll_div2_o), .osc_tick_o(osc_tick_o), .cpu_tick_o(cpu_tick_o),
        .mco_pin_o(mco_pin_o), .mco_pin_oe_n_o(mco_pin_oe_n_o), .pll_lock_o(pll_lock_o));

    mcg_src_model #(.HALF(3)) mcg_src_model_inst (
        .mclk_i(mclk_i), .run_i(run), .ext_clk_o(ext_clk), .pin_clk_o(pin_clk),
        .xtal_tick_o(xtal_tick), .rc_tick_o(rc_tick), .pll_tick_o(pll_tick));

    // A 40 MHz clock, 25 ns period.
    always #12.5 mclk_i = ~mclk_i;

    // Free-running tick and clock-out toggle counters; scenarios take differences.
    always @(posedge mclk_i) begin
        n_osc <= n_osc + int'(osc_tick_o === 1'b1);
        n_cpu <= n_cpu + int'(cpu_tick_o === 1'b1);
        mco_q <= mco_pin_o;
        n_mco <= n_mco + int'(mco_pin_o !== mco_q);
    end

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Options are static levels, so they only change while reset is held.
    task automatic do_reset(input mcg_src_t s, input logic [3:0] o, input logic [4:0] r);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        opt_i <= mcg_opt_t'{s, o[3], o[2], o[1], o[0]};
        run <= r;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus_i <= mcg_bus_t'{a, d, 1'b1, 1'b0};
        @(posedge mclk_i);
        bus_i <= '0;
    endtask

    // Read data stand only in the cycle after the read strobe.
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk_i);
        bus_i <= mcg_bus_t'{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk_i);
        bus_i <= '0;
        #1 chk(rdata_o, exp, what);
    endtask

    task automatic measure(input int cyc, output int dosc, output int dcpu);
        int o0;
        int c0;
        @(posedge mclk_i);
        #1 o0 = n_osc;
        c0 = n_cpu;
        repeat (cyc) @(posedge mclk_i);
        #1 dosc = n_osc - o0;
        dcpu = n_cpu - c0;
    endtask

    task automatic t_regs();
        logic [7:0] v;
        logic [7:0] st;
        do_reset(MCG_SRC_RC, 4'h0, 5'h08);
        rd_chk(`MCG_OFS_CTRL, `MCG_CTRL_RST, "ctrl reset");
        rd_chk(`MCG_OFS_TRIM, `MCG_TRIM_RST, "trim reset");
        chk(rc_trim_o, 8'hFF, "trim out reset");
        chk({7'h00, mco_pin_oe_n_o}, 8'h01, "pin free");
        rd_chk(4'hF, 8'h00, "unmapped");
        wr(`MCG_OFS_CTRL, 8'hFF);
        rd_chk(`MCG_OFS_CTRL, 8'h03, "ctrl bits");
        chk({7'h00, mco_pin_oe_n_o}, 8'h00, "pin driven");
        v = `MCG_TRIM_SEARCH;
        st = 8'h40;
        // Dichotomy steps as tuning software would make them.
        for (int i = 0; i < 8; i++) begin
            wr(`MCG_OFS_TRIM, v);
            @(posedge mclk_i);
            #1 chk(rc_trim_o, v, "trim out");
            v = (i % 2 == 0) ? v - st : v + st;
            st = st >> 1;
        end
        do_reset(MCG_SRC_RC, 4'h0, 5'h08);
        rd_chk(`MCG_OFS_TRIM, 8'hFF, "trim after reset");
        rd_chk(`MCG_OFS_CTRL, 8'h00, "ctrl after reset");
    endtask

    task automatic t_slow();
        int o;
        int c;
        int m;
        do_reset(MCG_SRC_RC, 4'h0, 5'h08);
        measure(640, o, c);
        chk(8'(o inside {[318:322]}), 8'h01, "rc rate");
        chk(8'((c - o) inside {[-1:1]}), 8'h01, "normal cpu");
        wr(`MCG_OFS_CTRL, 8'h03);
        repeat (80) @(posedge mclk_i);
        m = n_mco;
        measure(640, o, c);
        chk(8'(c inside {[9:11]}), 8'h01, "slow cpu");
        chk(8'(o inside {[318:322]}), 8'h01, "osc kept");
        chk(8'((n_mco - m - c) inside {[-1:1]}), 8'h01, "clock out rate");
        chk({7'h00, mco_pin_oe_n_o}, 8'h00, "clock out on");
    endtask

    task automatic t_src();
        int o;
        int c;
        do_reset(MCG_SRC_RC, 4'h0, 5'h01);
        measure(120, o, c);
        chk(8'(o), 8'h00, "rc ignores ext");
        chk({7'h00, tpll_div2_o}, 8'h00, "rc not halved");
        do_reset(MCG_SRC_EXT, 4'h1, 5'h01);
        measure(120, o, c);
        chk(8'(o > 0 && o <= 60), 8'h01, "ext used");
        chk({7'h00, tpll_div2_o}, 8'h01, "ext halved");
        do_reset(mcg_src_t'(2'b11), 4'h0, 5'h02);
        measure(120, o, c);
        chk(8'(o > 0 && o <= 60), 8'h01, "default pin");
        do_reset(MCG_SRC_XTAL, 4'h0, 5'h04);
        measure(120, o, c);
        chk(8'(o inside {[58:62]}), 8'h01, "xtal used");
        chk({7'h00, tpll_div2_o}, 8'h01, "xtal halved");
    endtask

    task automatic t_pll();
        int o;
        int c;
        int k;
        do_reset(MCG_SRC_RC, 4'hE, 5'h18);
        @(posedge mclk_i);
        #1 chk({6'h00, pll_mult_o}, 8'h03, "x8");
        chk({6'h00, pll_en_o, tpll_en_o}, 8'h03, "plls on");
        measure(ST - 4, o, c);
        chk(8'(o), 8'h00, "startup hold");
        k = ST - 2;
        while (pll_lock_o !== 1'b1 && k < ST + LK + 20) begin
            @(posedge mclk_i);
            #1 k++;
        end
        chk(8'(k >= ST && k < ST + LK + 20), 8'h01, "lock time");
        rd_chk(`MCG_OFS_STATUS, 8'h01, "lock flag");
        // A wake edge must restart the whole startup hold and lock sequence.
        @(posedge mclk_i);
        wake <= 1'b1;
        repeat (8) @(posedge mclk_i);
        #1 chk({7'h00, pll_lock_o}, 8'h00, "wake unlocks");
        measure(ST - 8, o, c);
        chk(8'(o), 8'h00, "wake hold");
        k = 0;
        while (pll_lock_o !== 1'b1 && k < ST + LK + 20) begin
            @(posedge mclk_i);
            #1 k++;
        end
        chk(8'(k > 0 && k < ST + LK + 20), 8'h01, "relock");
        @(posedge mclk_i);
        wake <= 1'b0;
        do_reset(MCG_SRC_RC, 4'h8, 5'h18);
        @(posedge mclk_i);
        #1 chk({6'h00, pll_mult_o}, 8'h02, "x4");
    endtask

    task automatic t_ftrim();
        @(posedge mclk_i);
        ftrim5_i <= 8'h5A;
        ftrim3_i <= 8'hA5;
        ftrim_load_i <= 1'b1;
        @(posedge mclk_i);
        ftrim_load_i <= 1'b0;
        rd_chk(`MCG_OFS_FTRIM5, 8'h5A, "factory 5v");
        wr(`MCG_OFS_FTRIM3, 8'h00);
        rd_chk(`MCG_OFS_FTRIM3, 8'hA5, "factory 3v");
        @(posedge mclk_i);
        prot_clear_i <= 1'b1;
        @(posedge mclk_i);
        prot_clear_i <= 1'b0;
        rd_chk(`MCG_OFS_FTRIM5, 8'hFF, "erase 5v");
        rd_chk(`MCG_OFS_FTRIM3, 8'hFF, "erase 3v");
    endtask

    // The tests take about two thousand cycles; this bound leaves ample margin.
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        stop_test();
    end

    initial begin
        t_regs();
        t_slow();
        t_src();
        t_pll();
        t_ftrim();
        stop_test();
    end
endmodule
